// *** common/ddcp_defs.svh ***
// Register indices, byte addresses, field positions and reset values
// for the down-converter path control block.
// Assumes inclusion by bare name from the package and the checker.
`ifndef DDCP_DEFS_SVH
`define DDCP_DEFS_SVH

// ==========================================================
// Register indices and byte addresses (address = 4 * index)
`define DDCP_IDX_ROUTING   8'h24
`define DDCP_IDX_DECIM     8'h25
`define DDCP_IDX_MIXER     8'h26
`define DDCP_IDX_STATUS    8'h28
`define DDCP_IDX_NCO_A     8'h2A
`define DDCP_IDX_NCO_B     8'h31
`define DDCP_ADDR_ROUTING  8'h90
`define DDCP_ADDR_DECIM    8'h94
`define DDCP_ADDR_MIXER    8'h98
`define DDCP_ADDR_STATUS   8'hA0
`define DDCP_ADDR_NCO_A    8'hA8
`define DDCP_ADDR_NCO_B    8'hC4

// ==========================================================
// Writable bit masks and reset values
`define DDCP_MASK_ROUTING  8'h3E
`define DDCP_MASK_DECIM    8'hF9
`define DDCP_MASK_MIXER    8'hFF
`define DDCP_RST_ROUTING   8'h00
`define DDCP_RST_DECIM     8'h00
`define DDCP_RST_MIXER     8'h00
`define DDCP_RST_NCO       32'h0000_0000

// ==========================================================
// Field positions
`define DDCP_AVG_BIT       5
`define DDCP_SEL_HI        4
`define DDCP_SEL_LO        3
`define DDCP_PATH_BIT      2
`define DDCP_FILT_BIT      1
`define DDCP_ROUTER_BIT    7
`define DDCP_RATIO_HI      6
`define DDCP_RATIO_LO      4
`define DDCP_REAL_BIT      3
`define DDCP_PHINV_BIT     0
`define DDCP_GAIN_A_HI     7
`define DDCP_GAIN_A_LO     6
`define DDCP_RES_A_BIT     5
`define DDCP_QR_A_BIT      4
`define DDCP_GAIN_B_HI     3
`define DDCP_GAIN_B_LO     2
`define DDCP_RES_B_BIT     1
`define DDCP_QR_B_BIT      0
`define DDCP_RATIO_MAX     3'h5

`endif

// *** common/ddcp_pkg.sv ***
// Types shared by the down-converter path control block.
// Assumes ddcp_defs.svh is on the include path.
package ddcp_pkg;
  `include "ddcp_defs.svh"

  typedef logic signed [17:0] ddcp_sample_t;
  typedef logic signed [19:0] ddcp_wide_t;

  typedef enum logic [1:0] {
    DDCP_ROUTE_STRAIGHT = 2'b00,
    DDCP_ROUTE_ALL_A    = 2'b01,
    DDCP_ROUTE_ALL_B    = 2'b10,
    DDCP_ROUTE_AVERAGE  = 2'b11
  } ddcp_route_e;

  typedef enum logic [1:0] {
    DDCP_GAIN_0DB = 2'b00,
    DDCP_GAIN_3DB = 2'b01,
    DDCP_GAIN_6DB = 2'b10,
    DDCP_GAIN_NA  = 2'b11
  } ddcp_gain_e;
endpackage

// *** verilog/ddcp_nco.sv ***
// Per-channel oscillator: phase accumulator with restart on restart-bit change.
// Assumes restartBit comes from a register on the same clock.
module ddcp_nco
  import ddcp_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        restartBit,
  input  wire logic [31:0] freqWord,
  input  wire logic        realMode,
  input  wire logic        phaseInvert,
  input  wire logic        advance,
  output logic             restartPulse,
  output logic [31:0]      phase,
  output logic [7:0]       restartCount
);
  logic        lastBit;
  logic [31:0] activeFreq;
  logic [31:0] phaseAcc;

  // Either edge of the bit counts, once per change
  assign restartPulse = restartBit ^ lastBit;

  always_ff @(posedge clock) begin
    if (rst) begin
      lastBit <= 1'b0;
    end else begin
      lastBit <= restartBit;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      activeFreq   <= `DDCP_RST_NCO;
      phaseAcc     <= 32'h0000_0000;
      restartCount <= 8'h00;
    end else if (restartPulse) begin
      activeFreq   <= realMode ? 32'h0000_0000 : freqWord;
      phaseAcc     <= 32'h0000_0000;
      restartCount <= restartCount + 8'h01;
    end else begin
      if (realMode) begin
        activeFreq <= 32'h0000_0000;
      end
      if (advance) begin
        phaseAcc <= phaseAcc + activeFreq;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      phase <= 32'h0000_0000;
    end else begin
      phase <= phaseInvert ? (32'h0000_0000 - phaseAcc) : phaseAcc;
    end
  end
endmodule // ddcp_nco

// *** verilog/ddcp_mix_gain.sv ***
// Per-channel mixer stage: optional quarter-rate mixing and post-mixer gain.
// Assumes one sample per inValid pulse, on the same clock.
module ddcp_mix_gain
  import ddcp_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire ddcp_sample_t sampleIn,
  input  wire logic         inValid,
  input  wire logic         active,
  input  wire logic         complexMode,
  input  wire logic         quarterRate,
  input  wire logic         restart,
  input  wire ddcp_gain_e   gainCode,
  output ddcp_wide_t        iOut,
  output ddcp_wide_t        qOut,
  output logic              outValid
);
  logic [1:0] quarterStep;
  ddcp_wide_t wideIn;
  ddcp_wide_t mixI;
  ddcp_wide_t mixQ;

  assign wideIn = ddcp_wide_t'(sampleIn);

  // About 1.414 by shifts; error is below 0.02 percent
  function automatic ddcp_wide_t applyGain(ddcp_wide_t x, ddcp_gain_e g);
    ddcp_wide_t r;
    r = x;
    if (g == DDCP_GAIN_3DB) begin
      r = x + (x >>> 2) + (x >>> 3) + (x >>> 5) + (x >>> 7);
    end else if (g == DDCP_GAIN_6DB) begin
      r = x <<< 1;
    end
    return r;
  endfunction

  // Sequence 1, -j, -1, +j
  always_comb begin
    mixI = wideIn;
    mixQ = '0;
    if (quarterRate && complexMode) begin
      case (quarterStep)
        2'd0: mixI = wideIn;
        2'd1: begin
          mixI = '0;
          mixQ = -wideIn;
        end
        2'd2: mixI = -wideIn;
        default: begin
          mixI = '0;
          mixQ = wideIn;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst || restart) begin
      quarterStep <= 2'd0;
    end else if (inValid) begin
      quarterStep <= quarterStep + 2'd1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      iOut     <= '0;
      qOut     <= '0;
      outValid <= 1'b0;
    end else begin
      outValid <= inValid;
      if (inValid) begin
        iOut <= active ? applyGain(mixI, gainCode) : wideIn;
        qOut <= (active && complexMode) ? applyGain(mixQ, gainCode) : '0;
      end
    end
  end
endmodule // ddcp_mix_gain

// *** verilog/ddcp_path_top.sv ***
// Down-converter path control: AHB-Lite registers, input routing,
// channel averaging, mixer stages, decimation and bypass.
// Assumes ADC samples arrive on the bus clock with a sampleValid strobe.
// Summary of operation
// - Averaging bit set gives the mean (A+B)/2; clear disables averaging.
// - Select 00 feeds channel A to converter A and B to B.
// - Select 01 feeds A to both converters; 10 feeds B to both.
// - Select 11 feeds the averaging stage output to both converters.
// - Path bit 0 bypasses digital features; 1 routes data through them.
// - One filter enable bit turns decimation on or off for both channels.
// - Routing select acts only while the router enable bit is set.
// - Common ratio code: bypass, 2, 4, 8, 16, 32; other codes unused.
// - Real mode bit: low-pass only, no complex mixing; clear means complex.
// - Phase bit 1 inverts oscillator phase; 0 leaves it unchanged.
// - Channel A gain code adds 0, 3 or 6 dB after mixer.
// - Channel B gain code uses the same encoding as channel A.
// - Toggling channel A restart bit resets phase and loads new word.
// - Toggling channel B restart bit resets phase and loads new word.
// - Channel A quarter-rate bit enables fs/4 mixing, complex mode only.
// - Channel B quarter-rate bit enables fs/4 mixing, complex mode only.
// - Oscillator takes a 32-bit word; forced to zero in real mode.
module ddcp_path_top
  import ddcp_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire ddcp_pkg::ddcp_sample_t adcA,
  input  wire ddcp_pkg::ddcp_sample_t adcB,
  input  wire logic              sampleValid,
  output ddcp_pkg::ddcp_wide_t   outIA,
  output ddcp_pkg::ddcp_wide_t   outQA,
  output ddcp_pkg::ddcp_wide_t   outIB,
  output ddcp_pkg::ddcp_wide_t   outQB,
  output logic                   outValid,
  output logic [31:0]            phaseA,
  output logic [31:0]            phaseB
);
  import ddcp_pkg::*;

  // ==========================================================
  // Bus slave
  logic              dataPhase;
  logic              dataWrite;
  logic [ADDR_W-1:0] dataAddr;
  logic [7:0]        routingReg;
  logic [7:0]        decimReg;
  logic [7:0]        mixerReg;
  logic [31:0]       ncoWordA;
  logic [31:0]       ncoWordB;
  logic [31:0]       statusWord;
  logic [31:0]       next_hrdata;
  logic              addrTaken;

  // Zero wait states; every transfer completes OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addrTaken = hsel && hready && htrans[1];

  always_ff @(posedge clock) begin
    if (rst) begin
      dataPhase <= 1'b0;
      dataWrite <= 1'b0;
      dataAddr  <= '0;
    end else if (hready) begin
      dataPhase <= addrTaken;
      dataWrite <= addrTaken && hwrite;
      dataAddr  <= haddr;
    end
  end

  // Reserved bits are not stored, so they read back as zero
  always_ff @(posedge clock) begin
    if (rst) begin
      routingReg <= `DDCP_RST_ROUTING;
      decimReg   <= `DDCP_RST_DECIM;
      mixerReg   <= `DDCP_RST_MIXER;
      ncoWordA   <= `DDCP_RST_NCO;
      ncoWordB   <= `DDCP_RST_NCO;
    end else if (dataPhase && dataWrite) begin
      if (dataAddr == ADDR_W'(`DDCP_ADDR_ROUTING)) begin
        routingReg <= hwdata[7:0] & `DDCP_MASK_ROUTING;
      end else if (dataAddr == ADDR_W'(`DDCP_ADDR_DECIM)) begin
        decimReg <= hwdata[7:0] & `DDCP_MASK_DECIM;
      end else if (dataAddr == ADDR_W'(`DDCP_ADDR_MIXER)) begin
        mixerReg <= hwdata[7:0] & `DDCP_MASK_MIXER;
      end else if (dataAddr == ADDR_W'(`DDCP_ADDR_NCO_A)) begin
        ncoWordA <= hwdata;
      end else if (dataAddr == ADDR_W'(`DDCP_ADDR_NCO_B)) begin
        ncoWordB <= hwdata;
      end
    end
  end

  // Read data is prepared in the address phase so it stands from a flop
  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (haddr == ADDR_W'(`DDCP_ADDR_ROUTING)) begin
      next_hrdata = {24'h00_0000, routingReg};
    end else if (haddr == ADDR_W'(`DDCP_ADDR_DECIM)) begin
      next_hrdata = {24'h00_0000, decimReg};
    end else if (haddr == ADDR_W'(`DDCP_ADDR_MIXER)) begin
      next_hrdata = {24'h00_0000, mixerReg};
    end else if (haddr == ADDR_W'(`DDCP_ADDR_STATUS)) begin
      next_hrdata = statusWord;
    end else if (haddr == ADDR_W'(`DDCP_ADDR_NCO_A)) begin
      next_hrdata = ncoWordA;
    end else if (haddr == ADDR_W'(`DDCP_ADDR_NCO_B)) begin
      next_hrdata = ncoWordB;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addrTaken && !hwrite) begin
      hrdata <= next_hrdata;
    end
  end

  // ==========================================================
  // Control decode
  logic        averageOn;
  ddcp_route_e routeSel;
  logic        pathOn;
  logic        filterOn;
  logic        routerOn;
  logic [2:0]  ratioCode;
  logic        realMode;
  logic        complexMode;

  assign averageOn   = routingReg[`DDCP_AVG_BIT];
  assign routeSel    = ddcp_route_e'(routingReg[`DDCP_SEL_HI:`DDCP_SEL_LO]);
  assign pathOn      = routingReg[`DDCP_PATH_BIT];
  assign filterOn    = routingReg[`DDCP_FILT_BIT];
  assign routerOn    = decimReg[`DDCP_ROUTER_BIT];
  assign ratioCode   = decimReg[`DDCP_RATIO_HI:`DDCP_RATIO_LO];
  assign realMode    = decimReg[`DDCP_REAL_BIT];
  assign complexMode = filterOn && !realMode;

  // ==========================================================
  // Routing and averaging
  ddcp_sample_t avgSample;
  ddcp_sample_t routedA;
  ddcp_sample_t routedB;
  logic         routedValid;
  logic signed [18:0] pairSum;

  assign pairSum = 19'(adcA) + 19'(adcB);

  // Without averaging the stage passes channel A through
  assign avgSample = averageOn ? ddcp_sample_t'(pairSum >>> 1) : adcA;

  always_ff @(posedge clock) begin
    if (rst) begin
      routedA     <= '0;
      routedB     <= '0;
      routedValid <= 1'b0;
    end else begin
      routedValid <= sampleValid && pathOn;
      if (sampleValid) begin
        if (!routerOn) begin
          routedA <= adcA;
          routedB <= adcB;
        end else begin
          case (routeSel)
            DDCP_ROUTE_STRAIGHT: begin
              routedA <= adcA;
              routedB <= adcB;
            end
            DDCP_ROUTE_ALL_A: begin
              routedA <= adcA;
              routedB <= adcA;
            end
            DDCP_ROUTE_ALL_B: begin
              routedA <= adcB;
              routedB <= adcB;
            end
            default: begin
              routedA <= avgSample;
              routedB <= avgSample;
            end
          endcase
        end
      end
    end
  end

  // ==========================================================
  // Oscillators and mixer stages
  logic       restartA;
  logic       restartB;
  logic [7:0] restartCountA;
  logic [7:0] restartCountB;
  ddcp_wide_t mixIA;
  ddcp_wide_t mixQA;
  ddcp_wide_t mixIB;
  ddcp_wide_t mixQB;
  logic       mixValid;

  ddcp_nco u_nco_a (
    .clock        (clock),
    .rst          (rst),
    .restartBit   (mixerReg[`DDCP_RES_A_BIT]),
    .freqWord     (ncoWordA),
    .realMode     (realMode),
    .phaseInvert  (decimReg[`DDCP_PHINV_BIT]),
    .advance      (routedValid && complexMode),
    .restartPulse (restartA),
    .phase        (phaseA),
    .restartCount (restartCountA)
  );

  ddcp_nco u_nco_b (
    .clock        (clock),
    .rst          (rst),
    .restartBit   (mixerReg[`DDCP_RES_B_BIT]),
    .freqWord     (ncoWordB),
    .realMode     (realMode),
    .phaseInvert  (decimReg[`DDCP_PHINV_BIT]),
    .advance      (routedValid && complexMode),
    .restartPulse (restartB),
    .phase        (phaseB),
    .restartCount (restartCountB)
  );

  ddcp_mix_gain u_mix_a (
    .clock       (clock),
    .rst         (rst),
    .sampleIn    (routedA),
    .inValid     (routedValid),
    .active      (filterOn),
    .complexMode (complexMode),
    .quarterRate (mixerReg[`DDCP_QR_A_BIT]),
    .restart     (restartA),
    .gainCode    (ddcp_gain_e'(mixerReg[`DDCP_GAIN_A_HI:`DDCP_GAIN_A_LO])),
    .iOut        (mixIA),
    .qOut        (mixQA),
    .outValid    (mixValid)
  );

  ddcp_mix_gain u_mix_b (
    .clock       (clock),
    .rst         (rst),
    .sampleIn    (routedB),
    .inValid     (routedValid),
    .active      (filterOn),
    .complexMode (complexMode),
    .quarterRate (mixerReg[`DDCP_QR_B_BIT]),
    .restart     (restartB),
    .gainCode    (ddcp_gain_e'(mixerReg[`DDCP_GAIN_B_HI:`DDCP_GAIN_B_LO])),
    .iOut        (mixIB),
    .qOut        (mixQB),
    .outValid    ()
  );

  // ==========================================================
  // Decimation (sample keep only; the filter taps are outside this block)
  logic [4:0] decimCount;
  logic [4:0] decimLast;
  logic       keepSample;

  // Unused codes fall back to no decimation
  always_comb begin
    decimLast = 5'd0;
    if (filterOn && ratioCode <= `DDCP_RATIO_MAX) begin
      decimLast = 5'((6'd1 << ratioCode) - 6'd1);
    end
  end

  assign keepSample = mixValid && (decimCount == 5'd0);

  always_ff @(posedge clock) begin
    if (rst || !pathOn) begin
      decimCount <= 5'd0;
    end else if (mixValid) begin
      decimCount <= (decimCount >= decimLast) ? 5'd0 : decimCount + 5'd1;
    end
  end

  // ==========================================================
  // Output select: bypass gives one-cycle latency
  always_ff @(posedge clock) begin
    if (rst) begin
      outIA    <= '0;
      outQA    <= '0;
      outIB    <= '0;
      outQB    <= '0;
      outValid <= 1'b0;
    end else if (!pathOn) begin
      outValid <= sampleValid;
      if (sampleValid) begin
        outIA <= ddcp_wide_t'(adcA);
        outIB <= ddcp_wide_t'(adcB);
        outQA <= '0;
        outQB <= '0;
      end
    end else begin
      outValid <= keepSample;
      if (keepSample) begin
        outIA <= mixIA;
        outQA <= mixQA;
        outIB <= mixIB;
        outQB <= mixQB;
      end
    end
  end

  // ==========================================================
  // Status
  assign statusWord = {8'h00, restartCountB, restartCountA,
                       4'h0, complexMode, filterOn && pathOn, pathOn, routerOn};
endmodule // ddcp_path_top

// *** sim/ddcp_path_assertions.sv ***
// Port-level checker for the down-converter path control block.
// Assumes ddcp_pkg is compiled first; bound to ddcp_path_top by the bench.
`include "ddcp_defs.svh"
module ddcp_path_assertions
  import ddcp_pkg::*;
#(
  parameter int ADDR_W = 8
)(
  input wire logic                   clock,
  input wire logic                   rst,
  input wire logic                   hsel,
  input wire logic [ADDR_W-1:0]      haddr,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic [31:0]            hwdata,
  input wire logic                   hready,
  input wire ddcp_pkg::ddcp_sample_t adcA,
  input wire ddcp_pkg::ddcp_sample_t adcB,
  input wire logic                   sampleValid,
  input wire ddcp_pkg::ddcp_wide_t   outIA,
  input wire ddcp_pkg::ddcp_wide_t   outQA,
  input wire ddcp_pkg::ddcp_wide_t   outIB,
  input wire ddcp_pkg::ddcp_wide_t   outQB,
  input wire logic                   outValid,
  input wire logic [31:0]            phaseA,
  input wire logic [31:0]            phaseB
);
  // ====================
  // Shadow of the routing and decimation registers
  logic              wrPend;
  logic [ADDR_W-1:0] wrAddr;
  logic [7:0]        route;
  logic [7:0]        decim;
  logic [3:0]        age;
  logic              quiet;
  ddcp_wide_t        avg;

  // Samples launched soon after a write may see old or new settings
  assign quiet = age > 4'h5;
  assign avg   = (ddcp_wide_t'(adcA) + ddcp_wide_t'(adcB)) >>> 1;

  always_ff @(posedge clock) begin
    if (rst) begin
      wrPend <= 1'b0;
      wrAddr <= '0;
    end else begin
      wrPend <= hsel && hready && htrans[1] && hwrite;
      wrAddr <= haddr;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      route <= 8'h00;
      decim <= 8'h00;
    end else if (wrPend && wrAddr == ADDR_W'(`DDCP_ADDR_ROUTING)) begin
      route <= hwdata[7:0];
    end else if (wrPend && wrAddr == ADDR_W'(`DDCP_ADDR_DECIM)) begin
      decim <= hwdata[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst || wrPend) begin
      age <= 4'h0;
    end else if (age != 4'hF) begin
      age <= age + 4'h1;
    end
  end

  // ====================
  // Properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence sLaunch;
    sampleValid && quiet && route[2] && !route[1];
  endsequence

  sequence sMux(logic [1:0] s);
    decim[7] && route[4:3] == s;
  endsequence

  AST_BYPASS_NEXT:
    assert property (sampleValid && quiet && !route[2] |=>
      outValid && outIA == ddcp_wide_t'($past(adcA)))
    else $error("bypassed sample not out one cycle later");
  AST_FULL_RATE:
    assert property (sLaunch |-> ##3 outValid)
    else $error("sample lost with filter off");
  AST_STRAIGHT:
    assert property (sLaunch ##0 (!decim[7] || route[4:3] == 2'b00) |-> ##3
      (outIA == ddcp_wide_t'($past(adcA, 3)) && outIB == ddcp_wide_t'($past(adcB, 3))))
    else $error("straight routing wrong");
  AST_ALL_A:
    assert property (sLaunch ##0 sMux(2'b01) |-> ##3
      (outIA == ddcp_wide_t'($past(adcA, 3)) && outIB == ddcp_wide_t'($past(adcA, 3))))
    else $error("channel A not on both converters");
  AST_AVERAGE:
    assert property (sLaunch ##0 sMux(2'b11) ##0 route[5] |-> ##3
      (outIA == $past(avg, 3) && outIB == $past(avg, 3)))
    else $error("average not on both converters");
  AST_REAL_NO_Q:
    assert property (outValid && quiet && route[2] && route[1] && decim[3] |->
      outQA == '0 && outQB == '0)
    else $error("quadrature output in real mode");
  AST_REAL_PHASE:
    assert property (quiet && decim[3] |=> $stable(phaseA) && $stable(phaseB))
    else $error("oscillator moved in real mode");
  AST_NO_STRAY:
    assert property (outValid |-> $past(sampleValid) || $past(sampleValid, 3))
    else $error("output with no sample behind it");
  AST_DECIM_HALF:
    assert property (outValid && quiet && route[2] && route[1] && decim[6:4] == 3'h1
      |=> !outValid)
    else $error("two outputs in a row at ratio 2");
endmodule // ddcp_path_assertions

// *** sim/tb_ddcp_path_top.sv ***
// Self-checking bench for the down-converter path control block.
// Assumes ddcp_pkg, the design and the checker are compiled first.
module tb_ddcp_path_top
  import ddcp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam ddcp_sample_t VA = 18'h0_1234;
  localparam ddcp_sample_t VB = 18'h3_F000;
  localparam ddcp_sample_t VM = 18'h0_011A;

  logic         clock, rst, hsel, hwrite, hready, hreadyout, hresp;
  logic         sampleValid, outValid;
  logic [7:0]   haddr;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [31:0]  hwdata, hrdata, phaseA, phaseB, rd, p1, q1;
  ddcp_sample_t adcA, adcB;
  ddcp_wide_t   outIA, outQA, outIB, outQB;
  int           errCount, testsRun, ovCount, lat;

  ddcp_path_top #(.ADDR_W(8)) uut (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .adcA(adcA),
    .adcB(adcB), .sampleValid(sampleValid), .outIA(outIA), .outQA(outQA),
    .outIB(outIB), .outQB(outQB), .outValid(outValid), .phaseA(phaseA),
    .phaseB(phaseB));
  assign hready = hreadyout;

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  always @(negedge clock) begin
    if (outValid === 1'b1) ovCount++;
  end

  // ====================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errCount++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Ready and read data are taken at the rising edge that samples them
  task automatic wait_rdy(output logic [31:0] q);
    logic r;
    int n;
    r = 1'b0;
    n = 0;
    while (r !== 1'b1) begin
      @(posedge clock);
      r = hready;
      q = hrdata;
      n++;
      if (n > 20) begin
        errCount++;
        test_done();
      end
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy(q);
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy(q);
    hsel <= 1'b0;
  endtask

  // Idle cycles first, so settings written just before have landed
  task automatic send(input ddcp_sample_t a, input ddcp_sample_t b);
    repeat (8) @(posedge clock);
    adcA <= a;
    adcB <= b;
    sampleValid <= 1'b1;
    @(posedge clock);
    sampleValid <= 1'b0;
    lat = 1;
    @(negedge clock);
    while (outValid !== 1'b1) begin
      @(negedge clock);
      lat++;
      if (lat > 12) begin
        errCount++;
        test_done();
      end
    end
  endtask

  function automatic logic [31:0] rot(input int k, input ddcp_sample_t x);
    case (k % 4)
      0: return x;
      2: return -x;
      default: return 32'h0000_0000;
    endcase
  endfunction

  // ====================
  // Scenarios
  task automatic test_regs();
    logic [7:0] ad [6] = '{8'h90, 8'h94, 8'h98, 8'hA0, 8'hA8, 8'hC4};
    logic [7:0] mk [3] = '{8'h3E, 8'hF9, 8'hFF};
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, ad[i], 32'h0000_0000, rd);
      check(rd, 32'h0000_0000);
    end
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, ad[i], 32'hFFFF_FFFF, rd);
      bus(1'b0, ad[i], 32'h0000_0000, rd);
      check(rd, {24'h00_0000, mk[i]});
      bus(1'b1, ad[i], 32'h0000_0000, rd);
    end
    bus(1'b1, 8'h40, 32'hFFFF_FFFF, rd);
    bus(1'b0, 8'h40, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000);
    bus(1'b0, 8'hA0, 32'h0000_0000, rd);
    check(rd, 32'h0002_0200);
    $display("register test finished");
  endtask

  task automatic test_routing();
    ddcp_sample_t ea [4] = '{VA, VA, VB, VM};
    ddcp_sample_t eb [4] = '{VB, VA, VB, VM};
    send(VA, VB);
    check(lat, 1);
    check(outIA, VA);
    check(outIB, VB);
    bus(1'b1, 8'h94, 32'h0000_0080, rd);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, 8'h90, 32'h0000_0024 | (s << 3), rd);
      send(VA, VB);
      check(lat, 3);
      check(outIA, ea[s]);
      check(outIB, eb[s]);
    end
    bus(1'b1, 8'h90, 32'h0000_003E, rd);
    send(VA, VB);
    check(outIA, VM);
    check(outIB, VM);
    bus(1'b1, 8'h94, 32'h0000_0000, rd);
    bus(1'b1, 8'h90, 32'h0000_002C, rd);
    send(VA, VB);
    check(outIB, VB);
    $display("routing test finished");
  endtask

  task automatic test_decim();
    bus(1'b1, 8'h90, 32'h0000_0000, rd);
    bus(1'b1, 8'h90, 32'h0000_0006, rd);
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, 8'h94, 32'h0000_0008 | (c << 4), rd);
      repeat (8) @(posedge clock);
      ovCount = 0;
      sampleValid <= 1'b1;
      repeat (64) @(posedge clock);
      sampleValid <= 1'b0;
      repeat (8) @(posedge clock);
      check(ovCount, (c < 6) ? (64 >> c) : 64);
    end
    bus(1'b1, 8'h94, 32'h0000_0008, rd);
    bus(1'b1, 8'h98, 32'h0000_0019, rd);
    send(VA, VB);
    check(outIA, VA);
    check(outIB, VB * 2);
    check(outQA, 32'h0000_0000);
    check(outQB, 32'h0000_0000);
    $display("decimation test finished");
  endtask

  task automatic test_osc();
    bus(1'b1, 8'h94, 32'h0000_0000, rd);
    bus(1'b1, 8'hA8, 32'h0100_0000, rd);
    bus(1'b1, 8'hC4, 32'h0030_0000, rd);
    bus(1'b0, 8'hA8, 32'h0000_0000, rd);
    check(rd, 32'h0100_0000);
    bus(1'b1, 8'h98, 32'h0000_0022, rd);
    bus(1'b0, 8'h98, 32'h0000_0000, rd);
    check(rd, 32'h0000_0022);
    bus(1'b0, 8'hA0, 32'h0000_0000, rd);
    check(rd, 32'h0003_030E);
    send(VA, VB);
    repeat (4) @(posedge clock);
    p1 = phaseA;
    q1 = phaseB;
    repeat (4) send(VA, VB);
    repeat (4) @(posedge clock);
    check(phaseA - p1, 32'h0400_0000);
    check(phaseB - q1, 32'h00C0_0000);
    p1 = phaseA;
    bus(1'b1, 8'h94, 32'h0000_0001, rd);
    repeat (4) @(posedge clock);
    check(phaseA, -p1);
    // Restart bits fall here, which must restart the rotation too
    bus(1'b1, 8'h94, 32'h0000_0000, rd);
    bus(1'b1, 8'h98, 32'h0000_0099, rd);
    for (int k = 0; k < 4; k++) begin
      send(VA, VB);
      check(outIA, rot(k, VA) * 2);
      check(outQA, rot(k + 1, VA) * 2);
      check(outIB, rot(k, VB) * 2);
      check(outQB, rot(k + 1, VB) * 2);
    end
    $display("oscillator test finished");
  endtask

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    adcA = '0;
    adcB = '0;
    sampleValid = 1'b0;
    errCount = 0;
    testsRun = 0;
    ovCount = 0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    test_regs();
    test_routing();
    test_decim();
    test_osc();
    test_done();
  end
endmodule // tb_ddcp_path_top

bind ddcp_path_top ddcp_path_assertions #(.ADDR_W(ADDR_W)) chk (
  .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .adcA(adcA),
  .adcB(adcB), .sampleValid(sampleValid), .outIA(outIA), .outQA(outQA),
  .outIB(outIB), .outQB(outQB), .outValid(outValid), .phaseA(phaseA),
  .phaseB(phaseB));
